// [uf_fifo_gate.sv]
// UART holding FIFOs, FIFO control register and register group gating
`include "uf_regs.svh"

module uf_fifo_gate import uf_pkg::*; #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_bit_tick,
  input wire logic i_rx,
  output logic o_tx,
  output uf_access_t o_access,
  output logic o_rx_trig,
  output logic o_tx_trig,
  output logic o_rx_clr_busy,
  output logic o_tx_clr_busy
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [1:0] CLR_C = 2'(`UF_CLR_CYCLES);

  // Trigger level 60 and pointer wrap need a power of two of 64 or more
  if (DEPTH < 64 || (1 << AW) != DEPTH || WIDTH != 8) begin : g_bad_cfg
    $error("uf_fifo_gate: DEPTH must be a power of two >= 64, WIDTH 8");
  end

  //----------------------------------------------------------------
  // Control registers
  //----------------------------------------------------------------
  uf_fctl_t fctl;
  logic [7:0] lfmt;
  logic [7:0] enhanced_feature_control;
  logic [7:0] modem;
  logic [1:0] rx_clr_cnt;
  logic [1:0] tx_clr_cnt;

  wire enh_en = enhanced_feature_control[`UF_EFR_ENH];
  wire dle = lfmt[`UF_LFMT_DLE];
  wire is_key = (lfmt == `UF_LFMT_ENH_KEY);

  // Group visibility follows the format, modem and enhanced control values
  // general group gate
  assign o_access.general = !dle;
  assign o_access.second = modem[`UF_MODEM_B2] && enh_en;
  assign o_access.special = dle && !is_key;
  assign o_access.enhanced = is_key;

  // Address decode; the selects are gated by the format value, every write and read strobe is qualified by clock enable
  wire sel_hold = (i_reg_addr == `UF_OFS_HOLD) && o_access.general;
  wire sel_efr = (i_reg_addr == `UF_OFS_FCTL) && is_key;
  wire sel_fctl = (i_reg_addr == `UF_OFS_FCTL) && !is_key && !dle;
  wire sel_modem = (i_reg_addr == `UF_OFS_MODEM) && !dle;
  wire wr_fctl = i_ce && i_reg_wr && sel_fctl;
  wire wr_efr = i_ce && i_reg_wr && sel_efr;
  wire wr_lfmt = i_ce && i_reg_wr && (i_reg_addr == `UF_OFS_LFMT);
  wire wr_modem = i_ce && i_reg_wr && sel_modem;
  wire wr_thr = i_ce && i_reg_wr && sel_hold;
  wire rd_rhr = i_ce && i_reg_rd && sel_hold;

  // Enhanced-only bits keep their value unless enhanced enable is set
  // transmit trigger guard
  wire [1:0] next_tx_trig = enh_en ? i_reg_wdata[5:4] : fctl.tx_trig;
  wire next_mb2 = enh_en ? i_reg_wdata[`UF_MODEM_B2] : modem[`UF_MODEM_B2];

  // Control register storage; the two clear bits are not stored
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      fctl <= `UF_FCTL_RST;
      lfmt <= `UF_LFMT_RST;
      enhanced_feature_control <= `UF_EFR_RST;
      modem <= `UF_MODEM_RST;
    end else begin
      if (wr_fctl) begin
        fctl <= {i_reg_wdata[7:6], next_tx_trig, 3'b000, i_reg_wdata[0]};
      end
      if (wr_lfmt) begin
        lfmt <= i_reg_wdata;
      end
      if (wr_efr) begin
        enhanced_feature_control <= i_reg_wdata;
      end
      if (wr_modem) begin
        modem <= {i_reg_wdata[7:3], next_mb2, i_reg_wdata[1:0]};
      end
    end
  end

  // Clear sequencers hold each FIFO empty for the full clear time
  // two crystal cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_clr_cnt <= 2'h0;
      tx_clr_cnt <= 2'h0;
    end else if (i_ce) begin
      if (wr_fctl && i_reg_wdata[1]) begin
        rx_clr_cnt <= CLR_C;
      end else if (rx_clr_cnt != 2'h0) begin
        rx_clr_cnt <= rx_clr_cnt - 2'h1;
      end
      if (wr_fctl && i_reg_wdata[2]) begin
        tx_clr_cnt <= CLR_C;
      end else if (tx_clr_cnt != 2'h0) begin
        tx_clr_cnt <= tx_clr_cnt - 2'h1;
      end
    end
  end
  assign o_rx_clr_busy = (rx_clr_cnt != 2'h0);
  assign o_tx_clr_busy = (tx_clr_cnt != 2'h0);

  //----------------------------------------------------------------
  // Receive shifter and FIFO
  //----------------------------------------------------------------
  uf_rx_st_t rx_st;
  logic [7:0] receive_shift_register;
  logic [2:0] rx_bit;
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] rx_wp;
  logic [AW-1:0] rx_rp;
  logic [CW-1:0] rx_cnt;

  // A disabled FIFO behaves as a single entry at location zero
  wire [CW-1:0] cap = fctl.fifo_en ? DEPTH_C : CW'(1);
  wire rx_done = i_ce && i_bit_tick && (rx_st == UF_RX_STOP) && i_rx;
  wire rx_push = rx_done && (rx_cnt < cap) && !o_rx_clr_busy;
  wire rx_pop = rd_rhr && (rx_cnt != '0) && !o_rx_clr_busy;

  // Receive shifter; the FIFO clear never touches it
  // deserialize on RX
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_st <= UF_RX_IDLE;
      receive_shift_register <= 8'h00;
      rx_bit <= 3'h0;
    end else if (i_ce && i_bit_tick) begin
      unique case (rx_st)
        UF_RX_IDLE: begin
          if (!i_rx) begin
            rx_st <= UF_RX_DATA;
            rx_bit <= 3'h0;
          end
        end
        UF_RX_DATA: begin
          receive_shift_register <= {i_rx, receive_shift_register[7:1]};
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == 3'h7) begin
            rx_st <= UF_RX_STOP;
          end
        end
        UF_RX_STOP: begin
          rx_st <= UF_RX_IDLE;
        end
        default: begin
          rx_st <= UF_RX_IDLE;
        end
      endcase
    end
  end

  // Receive FIFO pointers and count
  // entry zero when disabled
  always_ff @(posedge i_clk_sys) begin
    // Parking a disabled, empty FIFO must not swallow the arriving char
    if (i_sys_rst || (i_ce && !fctl.fifo_en && rx_cnt == '0 &&
        !rx_push)) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else if (i_ce) begin
      if (o_rx_clr_busy) begin
        rx_wp <= '0;
        rx_rp <= '0;
        rx_cnt <= '0;
      end else begin
        if (rx_push) begin
          rx_wp <= fctl.fifo_en ? rx_wp + AW'(1) : '0;
          rx_mem[rx_wp] <= receive_shift_register;
        end
        if (rx_pop) begin
          rx_rp <= fctl.fifo_en ? rx_rp + AW'(1) : '0;
        end
        rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
      end
    end
  end

  // Receive trigger level decode
  // receive trigger select
  wire [CW-1:0] rx_lvl = (fctl.rx_trig == 2'b00) ? CW'(`UF_RXT_0) :
                         (fctl.rx_trig == 2'b01) ? CW'(`UF_RXT_1) :
                         (fctl.rx_trig == 2'b10) ? CW'(`UF_RXT_2) :
                                                   CW'(`UF_RXT_3);
  assign o_rx_trig = (rx_cnt >= rx_lvl);

  //----------------------------------------------------------------
  // Transmit FIFO and shifter
  //----------------------------------------------------------------
  uf_tx_st_t tx_st;
  logic [7:0] transmit_shift_register;
  logic [2:0] tx_bit;
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp;
  logic [AW-1:0] tx_rp;
  logic [CW-1:0] tx_cnt;

  wire tx_push = wr_thr && (tx_cnt < cap) && !o_tx_clr_busy;
  wire tx_load = i_ce && (tx_st == UF_TX_IDLE) && (tx_cnt != '0) &&
                 !o_tx_clr_busy;

  // Transmit FIFO pointers and count
  // excess writes dropped
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else if (i_ce) begin
      if (o_tx_clr_busy || (!fctl.fifo_en && tx_cnt == '0 && !tx_push)) begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt <= '0;
      end else begin
        if (tx_push) begin
          tx_wp <= fctl.fifo_en ? tx_wp + AW'(1) : '0;
          tx_mem[tx_wp] <= i_reg_wdata;
        end
        if (tx_load) begin
          tx_rp <= fctl.fifo_en ? tx_rp + AW'(1) : '0;
        end
        tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_load);
      end
    end
  end

  // Transmit shifter: start bit, eight data bits LSB first, stop bit
  // serialize onto TX
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_st <= UF_TX_IDLE;
      transmit_shift_register <= 8'h00;
      tx_bit <= 3'h0;
      o_tx <= 1'b1;
    end else if (tx_load) begin
      transmit_shift_register <= tx_mem[tx_rp];
      tx_st <= UF_TX_START;
    end else if (i_ce && i_bit_tick) begin
      unique case (tx_st)
        UF_TX_IDLE: o_tx <= 1'b1;
        UF_TX_START: begin
          o_tx <= 1'b0;
          tx_bit <= 3'h0;
          tx_st <= UF_TX_DATA;
        end
        UF_TX_DATA: begin
          o_tx <= transmit_shift_register[0];
          transmit_shift_register <= {1'b0, transmit_shift_register[7:1]};
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == 3'h7) begin
            tx_st <= UF_TX_STOP;
          end
        end
        UF_TX_STOP: begin
          o_tx <= 1'b1;
          tx_st <= UF_TX_IDLE;
        end
      endcase
    end
  end

  // Transmit trigger counts free spaces; without enhanced enable it
  // falls back to the lowest level
  // transmit trigger select
  wire [1:0] tx_sel = enh_en ? fctl.tx_trig : 2'b00;
  wire [CW-1:0] tx_lvl = (tx_sel == 2'b00) ? CW'(`UF_TXT_0) :
                         (tx_sel == 2'b01) ? CW'(`UF_TXT_1) :
                         (tx_sel == 2'b10) ? CW'(`UF_TXT_2) :
                                             CW'(`UF_TXT_3);
  assign o_tx_trig = ((DEPTH_C - tx_cnt) >= tx_lvl);

  //----------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------
  // FIFO control reads back as zero since it cannot be read
  // write-only control
  wire [7:0] next_rdata = sel_hold ? rx_mem[rx_rp] :
                          sel_efr ? enhanced_feature_control :
                          (i_reg_addr == `UF_OFS_LFMT) ? lfmt :
                          sel_modem ? modem : 8'h00;

  // Read data appears one cycle after the read strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce && i_reg_rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  property p_gen_gate;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      wr_lfmt |=> (o_access.general == !$past(i_reg_wdata[7]));
  endproperty
  a_gen_gate: assert property (p_gen_gate)
    else $error("general group gate wrong after format write");

  property p_enh_guard;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_fctl && !enh_en) |=> $stable(fctl.tx_trig);
  endproperty
  a_enh_guard: assert property (p_enh_guard)
    else $error("transmit trigger changed without enhanced enable");

  property p_rx_clr;
    @(posedge i_clk_sys) disable iff (i_sys_rst || !i_ce)
      (wr_fctl && i_reg_wdata[1]) |=> o_rx_clr_busy [*2] ##1
      (!o_rx_clr_busy && rx_cnt == '0);
  endproperty
  a_rx_clr: assert property (p_rx_clr)
    else $error("receive clear did not last two cycles and empty");

  property p_tx_clr;
    @(posedge i_clk_sys) disable iff (i_sys_rst || !i_ce)
      (wr_fctl && i_reg_wdata[2]) |=> ##1 (tx_cnt == '0) ##1
      !o_tx_clr_busy;
  endproperty
  a_tx_clr: assert property (p_tx_clr)
    else $error("transmit clear did not empty and release");

  property p_special;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_access.special |-> (lfmt[7] && lfmt != 8'hbf);
  endproperty
  a_special: assert property (p_special)
    else $error("special set open in wrong format");

  property p_enh_set;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_efr || (i_ce && i_reg_wr && i_reg_addr == `UF_OFS_FCTL &&
      o_access.enhanced)) |-> (lfmt == 8'hbf);
  endproperty
  a_enh_set: assert property (p_enh_set)
    else $error("enhanced registers reached without key value");

  property p_second;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_access.second |-> (modem[2] && enhanced_feature_control[4]);
  endproperty
  a_second: assert property (p_second)
    else $error("second group open without both enables");

  property p_overflow;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_thr && tx_cnt == cap && !tx_load && !o_tx_clr_busy) |=>
      $stable(tx_cnt);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("full transmit FIFO accepted a byte");

  property p_rx_single;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !fctl.fifo_en |=> (rx_cnt <= CW'(1));
  endproperty
  a_rx_single: assert property (p_rx_single)
    else $error("disabled receive FIFO holds more than one entry");

  property p_fctl_rd;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && i_reg_rd && sel_fctl) |=> (o_reg_rdata == 8'h00);
  endproperty
  a_fctl_rd: assert property (p_fctl_rd)
    else $error("FIFO control value visible on read");

  property p_rx_trig;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (fctl.rx_trig == 2'b11) |-> (o_rx_trig == (rx_cnt >= CW'(60)));
  endproperty
  a_rx_trig: assert property (p_rx_trig)
    else $error("receive trigger at 60 mismatched");

  c_rx_full: cover property (@(posedge i_clk_sys) rx_cnt == DEPTH_C);
  c_tx_send: cover property (@(posedge i_clk_sys) tx_load ##[1:200]
    (tx_st == UF_TX_STOP));
  c_clr_both: cover property (@(posedge i_clk_sys)
    o_rx_clr_busy && o_tx_clr_busy);

endmodule

// [uf_regs.svh]
// Register offsets, field positions, reset values and timing counts
//------------------------------------------------------------------
//------------------------------------------------------------------
`ifndef UF_REGS_SVH
`define UF_REGS_SVH

// Register offsets on the host register port
`define UF_OFS_HOLD 4'h0
`define UF_OFS_FCTL 4'h2
`define UF_OFS_LFMT 4'h3
`define UF_OFS_MODEM 4'h4

// Field positions
`define UF_LFMT_DLE 7
`define UF_EFR_ENH 4
`define UF_MODEM_B2 2
`define UF_LFMT_ENH_KEY 8'hbf

// Reset values
`define UF_FCTL_RST 8'h00
`define UF_LFMT_RST 8'h00
`define UF_EFR_RST 8'h00
`define UF_MODEM_RST 8'h00

// Trigger levels (receive in characters, transmit in spaces)
`define UF_RXT_0 8
`define UF_RXT_1 16
`define UF_RXT_2 56
`define UF_RXT_3 60
`define UF_TXT_0 8
`define UF_TXT_1 16
`define UF_TXT_2 32
`define UF_TXT_3 56

// FIFO clear time in crystal periods; the crystal runs as i_clk_sys
`define UF_CLR_XTAL_PERIODS 2
`define UF_CLR_CYCLES (`UF_CLR_XTAL_PERIODS * 1)

`endif

// [uf_pkg.sv]
// Types shared by the FIFO and register gating block
package uf_pkg;

  // FIFO control register layout
  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic rsvd;
    logic tx_clr;
    logic rx_clr;
    logic fifo_en;
  } uf_fctl_t;

  // Which register groups the host may reach
  typedef struct packed {
    logic general;
    logic second;
    logic special;
    logic enhanced;
  } uf_access_t;

  typedef enum logic [1:0] {
    UF_RX_IDLE = 2'b00,
    UF_RX_DATA = 2'b01,
    UF_RX_STOP = 2'b10
  } uf_rx_st_t;

  typedef enum logic [1:0] {
    UF_TX_IDLE = 2'b00,
    UF_TX_START = 2'b01,
    UF_TX_DATA = 2'b10,
    UF_TX_STOP = 2'b11
  } uf_tx_st_t;

endpackage

// [uf_serial_far.sv]
// Serial far-side model: sends frames to the receiver, captures transmit frames
module uf_serial_far (
  input wire logic i_clk_sys,
  input wire logic i_bit_tick,
  input wire logic i_line_in,
  output logic o_line_out
);
  logic [7:0] got [$];
  logic [3:0] cap_cnt;
  logic [7:0] cap_sh;

  // Line idles high, as a real UART peer would leave it
  initial begin
    o_line_out = 1'b1;
    cap_cnt = 4'h0;
    cap_sh = 8'h00;
  end

  // Step to the next baud tick, then move off the sampling edge
  task automatic next_bit();
    do @(posedge i_clk_sys); while (i_bit_tick !== 1'b1);
    @(negedge i_clk_sys);
  endtask

  // One 8N1 frame, LSB first; ticks must be running
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    @(negedge i_clk_sys);
    for (int k = 0; k < 10; k++) begin
      o_line_out = frame[k];
      next_bit();
    end
  endtask

  // Capture at ticks; value seen is the bit shown since the last tick
  always @(posedge i_clk_sys) begin
    if (i_bit_tick === 1'b1) begin
      if (cap_cnt == 4'h0) begin
        if (i_line_in === 1'b0) cap_cnt <= 4'h1;
      end else if (cap_cnt < 4'h9) begin
        cap_sh <= {i_line_in, cap_sh[7:1]};
        cap_cnt <= cap_cnt + 4'h1;
      end else begin
        if (i_line_in === 1'b1) got.push_back(cap_sh);
        cap_cnt <= 4'h0;
      end
    end
  end
endmodule

// [uf_fifo_gate_tb.sv]
// Self-checking testbench for the FIFO and register gating block
`include "uf_regs.svh"
`define UFT_CHECK(what, exp, seen) \
  begin \
    n_compared++; \
    if ((seen) !== (exp)) begin \
      num_errors++; \
      $display("mismatch %s exp %0h seen %0h", what, exp, seen); \
    end \
  end

module uf_fifo_gate_tb import uf_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [3:0] i_reg_addr = 4'h0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic i_bit_tick = 1'b0;
  logic rx_line;
  logic o_tx;
  uf_access_t o_access;
  logic o_rx_trig;
  logic o_tx_trig;
  logic o_rx_clr_busy;
  logic o_tx_clr_busy;
  logic tick_on = 1'b1;
  logic [1:0] tick_div = 2'h0;
  logic [7:0] d;
  int num_errors = 0;
  int n_compared = 0;
  int rx_lvl [4] = '{`UF_RXT_0, `UF_RXT_1, `UF_RXT_2, `UF_RXT_3};
  int tx_lvl [4] = '{`UF_TXT_0, `UF_TXT_1, `UF_TXT_2, `UF_TXT_3};

  // ----------------------------------------
  // Clock, baud tick and instances
  // ----------------------------------------
  always #2 i_clk_sys = ~i_clk_sys;

  // Tick every fourth cycle keeps frames short; can be paused to stall TX
  always @(negedge i_clk_sys) begin
    tick_div <= tick_div + 2'h1;
    i_bit_tick <= tick_on && (tick_div == 2'h3);
  end

  uf_fifo_gate u_dut (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_bit_tick(i_bit_tick), .i_rx(rx_line), .o_tx(o_tx),
    .o_access(o_access), .o_rx_trig(o_rx_trig), .o_tx_trig(o_tx_trig),
    .o_rx_clr_busy(o_rx_clr_busy), .o_tx_clr_busy(o_tx_clr_busy)
  );

  uf_serial_far u_far (
    .i_clk_sys(i_clk_sys), .i_bit_tick(i_bit_tick),
    .i_line_in(o_tx), .o_line_out(rx_line)
  );

  // ----------------------------------------
  // Register port and helper tasks
  // ----------------------------------------
  // One-cycle strobe; a gap cycle follows so strobes never collide
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask

  // Single reads only, never bursts
  // single reads
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
    v = o_reg_rdata;
  endtask

  // Busy must last the clear time; also the host's post-clear wait
  // host wait
  task automatic clr_wait(input logic is_tx);
    int n;
    n = 0;
    for (int k = 0; k < 6; k++) begin
      if ((is_tx ? o_tx_clr_busy : o_rx_clr_busy) === 1'b1) n++;
      @(negedge i_clk_sys);
    end
    `UFT_CHECK("clear busy cycles", `UF_CLR_CYCLES, n)
  endtask

  task automatic wait_got(input int n);
    for (int k = 0; k < 400 && u_far.got.size() < n; k++)
      @(negedge i_clk_sys);
  endtask

  // Fill the stalled TX FIFO to exactly the free-space level, then past it
  task automatic tx_level(input logic [1:0] c, input int lvl);
    wr(`UF_OFS_FCTL, {2'b00, c, 4'b0101});
    clr_wait(1'b1);
    for (int k = 0; k < 64 - lvl; k++) wr(`UF_OFS_HOLD, 8'(k));
    @(negedge i_clk_sys);
    `UFT_CHECK("tx trigger at level", 1'b1, o_tx_trig)
    wr(`UF_OFS_HOLD, 8'hee);
    @(negedge i_clk_sys);
    `UFT_CHECK("tx trigger below level", 1'b0, o_tx_trig)
  endtask

  task automatic acc(input logic [3:0] e);
    @(negedge i_clk_sys);
    `UFT_CHECK("access groups", e, o_access)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `UFT_CHECK("reset access", 4'b1000, o_access)
    `UFT_CHECK("reset rx trig", 1'b0, o_rx_trig)
    `UFT_CHECK("reset tx trig", 1'b1, o_tx_trig)
    `UFT_CHECK("reset tx idle", 1'b1, o_tx)
    rd(4'hf, d);
    `UFT_CHECK("unmapped read", 8'h00, d)
  endtask

  // Depth one while disabled: third byte finds the slot full and is lost
  task automatic t_tx_disabled();
    wr(`UF_OFS_HOLD, 8'h96);
    wr(`UF_OFS_HOLD, 8'h69);
    wr(`UF_OFS_HOLD, 8'hc3);
    wait_got(2);
    repeat (100) @(negedge i_clk_sys);
    `UFT_CHECK("tx byte fifo off", 8'h96, u_far.got[0])
    `UFT_CHECK("tx second byte", 8'h69, u_far.got[1])
    `UFT_CHECK("tx frames fifo off", 2, u_far.got.size())
  endtask

  // Depth one while disabled: second char dropped, first kept
  task automatic t_rx_disabled();
    u_far.send(8'ha5);
    u_far.send(8'h3c);
    rd(`UF_OFS_HOLD, d);
    `UFT_CHECK("rx entry zero", 8'ha5, d)
  endtask

  // Shifter loaded but stalled; trigger bits must not move without enhance
  task automatic t_tx_plain();
    tick_on = 1'b0;
    wr(`UF_OFS_HOLD, 8'h5a);
    repeat (3) @(negedge i_clk_sys);
    tx_level(2'b11, `UF_TXT_0);
  endtask

  task automatic t_gating();
    wr(`UF_OFS_MODEM, 8'h04);
    acc(4'b1000);
    wr(`UF_OFS_LFMT, 8'h80);
    acc(4'b0010);
    wr(`UF_OFS_LFMT, `UF_LFMT_ENH_KEY);
    acc(4'b0001);
    wr(`UF_OFS_FCTL, 8'h10);
    wr(`UF_OFS_LFMT, 8'h00);
    acc(4'b1000);
    wr(`UF_OFS_MODEM, 8'h04);
    acc(4'b1100);
    // A write with clock enable low must leave the format untouched
    i_ce = 1'b0;
    wr(`UF_OFS_LFMT, 8'h80);
    i_ce = 1'b1;
    acc(4'b1100);
  endtask

  // After all clears the stalled shifter byte must still go out alone
  task automatic t_tx_levels();
    for (int c = 0; c < 4; c++) tx_level(2'(c), tx_lvl[c]);
    wr(`UF_OFS_FCTL, 8'h05);
    clr_wait(1'b1);
    u_far.got.delete();
    tick_on = 1'b1;
    wait_got(1);
    `UFT_CHECK("shifter kept", 8'h5a, u_far.got[0])
    repeat (100) @(negedge i_clk_sys);
    `UFT_CHECK("frames after clear", 1, u_far.got.size())
  endtask

  task automatic t_rx_levels();
    for (int c = 0; c < 4; c++) begin
      wr(`UF_OFS_FCTL, {2'(c), 6'b000011});
      clr_wait(1'b0);
      for (int k = 0; k < rx_lvl[c] - 1; k++) u_far.send(8'(k));
      @(negedge i_clk_sys);
      `UFT_CHECK("rx trig below", 1'b0, o_rx_trig)
      u_far.send(8'(rx_lvl[c] - 1));
      @(negedge i_clk_sys);
      `UFT_CHECK("rx trig at level", 1'b1, o_rx_trig)
    end
    // Five more chars: one past full must be dropped, not overwrite
    for (int k = 60; k < 65; k++) u_far.send(8'(k));
    for (int k = 0; k < 64; k++) begin
      rd(`UF_OFS_HOLD, d);
      `UFT_CHECK("rx order", 8'(k), d)
    end
    @(negedge i_clk_sys);
    `UFT_CHECK("rx trig drained", 1'b0, o_rx_trig)
    rd(`UF_OFS_FCTL, d);
    `UFT_CHECK("fifo control read", 8'h00, d)
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is near 7000 cycles; over five times that means a hang
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (20) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    t_reset();
    t_tx_disabled();
    t_rx_disabled();
    t_tx_plain();
    t_gating();
    t_tx_levels();
    t_rx_levels();
    finish_test();
  end
endmodule
